/* File: core/burst_dram_controller_core.sv */
// Functional notes
// R1 - write latch enables pulse high per bank during data writes only
// R2 - mode 00 drives data transmit low for the bank being read
// R3 - mode 00 drives instruction transmit low for the bank fetched
// R4 - simple, pipelined and burst accesses accepted on both sides
// R5 - refresh generated internally at the configured rate
// R6 - same-block instruction and data accesses run one after another
// R7 - two 32-bit banks interleaved, one burst word per clock
// R8 - per-byte column strobes allow 8, 16 and 32 bit writes
// R9 - software keeps unaligned accesses inside one word
// R10 - first 32-bit read after reset supplies the setup word
// R11 - chained reset output released once configured
// R12 - host configures whole chain before ordinary accesses
// R13 - after setup only addresses in the programmed block answer
// R14 - setup bit 16 selects byte order of lanes
// R15 - setup bit 18 selects one or two clock burst writes
// R16 - setup bit 17 selects row strobe of 3 or 4 clocks
// R17 - buffer mode remaps the four multi-mode buffer outputs
// R18 - DRAM densities 64 Kbit to 4 Mbit selectable
// R19 - setup word governs all later operation
// R20 - chained reset held low during reset and until configured
// R21 - next bank indicator shows 1 when bank B is next
// R22 - size codes 0..3 give 512 KB, 2, 8, 32 MB blocks
// R23 - no reconfiguration until reset is asserted again
`timescale 1ns/1ps
`default_nettype none
module burst_dram_controller_core #(
   parameter int FIFO_DEPTH = dram_ctrl_pkg::REQ_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        rst_in,
   // processor channel
   input  wire logic [31:0] addr_in,
   input  wire logic        bus_invalid_n_in,
   input  wire logic        read_not_write_in,
   input  wire logic        data_req_n_in,
   input  wire logic        data_burst_req_n_in,
   input  wire logic [1:0]  data_req_type_n_in,
   input  wire logic [2:0]  data_opt_n_in,
   input  wire logic        instr_req_n_in,
   input  wire logic        instr_burst_req_n_in,
   input  wire logic        instr_req_type_in,
   output logic             data_ready_n_out,
   output logic             data_burst_ack_n_out,
   output logic             instr_ready_n_out,
   output logic             instr_burst_ack_n_out,
   output logic             pipeline_enable_n_out,
   // chain
   output logic             chain_reset_n_out,
   // dram array
   output logic [10:0]      dram_addr_a_out,
   output logic [10:0]      dram_addr_b_out,
   output logic             row_strobe_a_n_out,
   output logic             row_strobe_b_n_out,
   output logic [3:0]       col_strobe_a_n_out,
   output logic [3:0]       col_strobe_b_n_out,
   output logic             mem_write_a_n_out,
   output logic             mem_write_b_n_out,
   // bus buffers
   output logic [1:0]       write_latch_enable_bank_out,
   output logic [3:0]       buffer_ctrl_out
);
   import dram_ctrl_pkg::*;

   generate
      if (FIFO_DEPTH < 2) begin : g_bad_param
         $error("FIFO_DEPTH must be at least 2");
      end
   endgenerate

   setup_t      setup;
   logic        configured;
   state_t      state;
   req_t        cur;
   logic [3:0]  cnt;
   logic [2:0]  refresh_pending;
   logic [3:0]  prescale;
   logic [5:0]  divider;
   logic        refresh_tick;
   req_t        hold;
   logic        hold_valid;

   // request decode
   logic        bus_valid;
   logic        data_ok;
   logic        instr_ok;
   logic        cfg_capture;
   logic [3:0]  data_lanes;
   req_t        data_req;
   req_t        instr_req;
   req_t        push_req;
   logic        push_valid;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic        fifo_pop;
   req_t        fifo_head;

   function automatic logic in_block(input logic [31:0] a,
                                     input setup_t s);
      logic [31:0] m;
      m = block_mask(s.size);
      return (a & m) == ({s.base, 19'h0_0000} & m);
   endfunction

   // R14 byte order: lane index from byte address
   function automatic logic [3:0] lane_mask(input logic [2:0] opt,
                                            input logic [1:0] a,
                                            input logic big);
      logic [1:0] l;
      l = big ? ~a : a;
      case (opt)
         OPT_BYTE: return 4'h1 << l;
         OPT_HALF: return l[1] ? 4'hc : 4'h3;
         default:  return LANES_ALL;
      endcase
   endfunction

   assign bus_valid   = bus_invalid_n_in;
   // R10 setup capture on first word read
   assign cfg_capture = !configured && bus_valid && !data_req_n_in &&
                        read_not_write_in && data_req_type_n_in == 2'h0 &&
                        data_opt_n_in == OPT_WORD;
   // R13 block decode
   assign data_ok  = configured && bus_valid && !data_req_n_in &&
                     data_req_type_n_in == 2'h0 &&
                     data_opt_n_in <= OPT_HALF && in_block(addr_in, setup);
   assign instr_ok = configured && bus_valid && !instr_req_n_in &&
                     !instr_req_type_in && in_block(addr_in, setup);
   // R8 byte lanes
   assign data_lanes = lane_mask(data_opt_n_in, addr_in[1:0],
                                 setup.big_endian);
   assign data_req   = '{instr: 1'b0, write: !read_not_write_in,
                         burst: !data_burst_req_n_in, addr: addr_in,
                         lanes: data_lanes};
   assign instr_req  = '{instr: 1'b1, write: 1'b0,
                         burst: !instr_burst_req_n_in, addr: addr_in,
                         lanes: LANES_ALL};
   assign push_valid = hold_valid || data_ok || instr_ok;
   assign push_req   = hold_valid ? hold : (data_ok ? data_req : instr_req);

   // R6 a clashing instruction waits one slot behind the data request
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         hold_valid <= 1'b0;
         hold       <= '0;
      end else if (fifo_in_ready) begin
         hold_valid <= instr_ok && (hold_valid || data_ok);
         hold       <= instr_req;
      end
   end

   // R4 pipelined requests queue behind the running access
   req_fifo #(
      .WIDTH ($bits(req_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_req_fifo (
      .clk_in        (core_clk_in),
      .rst_in        (rst_in),
      .in_valid_in   (push_valid),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (push_req),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (fifo_pop),
      .out_data_out  (fifo_head)
   );

   // R10 R19 setup capture, R23 held until reset
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         configured <= 1'b0;
         setup      <= decode_setup(SETUP_WORD_RESET);
      end else if (cfg_capture) begin
         configured <= 1'b1;
         setup      <= decode_setup(addr_in);
      end
   end

   // R5 refresh rate: clock / (16 * (value + 1))
   always_ff @(posedge core_clk_in) begin
      if (rst_in || !configured) begin
         prescale     <= '0;
         divider      <= '0;
         refresh_tick <= 1'b0;
      end else begin
         prescale     <= prescale + 4'h1;
         refresh_tick <= 1'b0;
         if (prescale == REFRESH_PRESCALE) begin
            divider <= (divider == setup.refresh) ? 6'h0 : divider + 6'h1;
            refresh_tick <= (divider == setup.refresh);
         end
      end
   end

   // sequencer helpers
   logic [3:0]  ras_len;
   logic        col_last;
   logic        fast_word;
   logic        word_done;
   logic        burst_held;
   logic        page_end;
   logic        active;
   logic        refr_done;
   logic [23:0] word_idx;
   logic [10:0] row_addr;
   logic [10:0] col_addr;

   // R16 row strobe, R18 R22 size code picks address width
   assign ras_len    = setup.ras_short ? RAS_SHORT_CYCLES : RAS_LONG_CYCLES;
   assign col_last   = (cnt == ras_len - 4'h2);
   // R15 burst write pace
   assign fast_word  = !cur.write || setup.burst_fast;
   assign word_done  = (state == ST_COL && col_last) ||
                       (state == ST_BURST && (fast_word || cnt[0]));
   assign burst_held = cur.instr ? !instr_burst_req_n_in
                                 : !data_burst_req_n_in;
   assign word_idx   = cur.addr[26:3];
   assign col_addr   = word_idx[10:0] & col_mask(setup.size);
   assign row_addr   = 11'(word_idx >> (4'h8 + {2'h0, setup.size})) &
                       col_mask(setup.size);
   assign page_end   = cur.addr[2] && col_addr == col_mask(setup.size);
   assign active     = state == ST_COL || state == ST_BURST;
   assign refr_done  = state == ST_REFR && cnt == REFRESH_RAS_CYCLES;
   assign fifo_pop   = state == ST_IDLE && refresh_pending == '0 &&
                       fifo_out_valid;

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         refresh_pending <= '0;
      end else if (refresh_tick && !refr_done) begin
         refresh_pending <= refresh_pending + {2'h0, refresh_pending != 3'h7};
      end else if (refr_done && !refresh_tick) begin
         refresh_pending <= refresh_pending - 3'h1;
      end
   end

   // R6 one access at a time, R7 burst walks the banks
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         state <= ST_IDLE;
         cnt   <= '0;
         cur   <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               cnt <= '0;
               if (refresh_pending != '0) begin
                  state <= ST_REFR;
               end else if (fifo_out_valid) begin
                  cur   <= fifo_head;
                  state <= ST_ROW;
               end
            end
            ST_ROW: begin
               state <= ST_COL;
            end
            ST_COL, ST_BURST: begin
               cnt <= cnt + 4'h1;
               if (word_done) begin
                  cnt <= '0;
                  if (cur.burst && burst_held && !page_end) begin
                     cur.addr <= cur.addr + 32'h4;
                     state    <= ST_BURST;
                  end else begin
                     state <= ST_PRECH;
                  end
               end
            end
            ST_PRECH: begin
               cnt <= cnt + 4'h1;
               if (cnt == PRECHARGE_CYCLES - 4'h1) begin
                  state <= ST_IDLE;
                  cnt   <= '0;
               end
            end
            ST_REFR: begin
               cnt <= cnt + 4'h1;
               if (refr_done) begin
                  state <= ST_PRECH;
                  cnt   <= '0;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // R20 R11 chained reset follows configuration
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         chain_reset_n_out <= 1'b0;
      end else begin
         chain_reset_n_out <= configured;
      end
   end

   // channel handshake outputs
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         data_ready_n_out      <= 1'b1;
         instr_ready_n_out     <= 1'b1;
         data_burst_ack_n_out  <= 1'b1;
         instr_burst_ack_n_out <= 1'b1;
         pipeline_enable_n_out <= 1'b1;
      end else begin
         data_ready_n_out  <= !((word_done && !cur.instr) || cfg_capture);
         instr_ready_n_out <= !(word_done && cur.instr);
         data_burst_ack_n_out  <= !(active && cur.burst && !cur.instr &&
                                    !page_end);
         instr_burst_ack_n_out <= !(active && cur.burst && cur.instr &&
                                    !page_end);
         pipeline_enable_n_out <= !(configured && fifo_in_ready &&
                                    !hold_valid);
      end
   end

   // dram strobes and addresses
   logic bank_b;
   logic next_bank;
   assign bank_b    = cur.addr[2];
   // R21 next bank follows the burst or the queued request
   assign next_bank = active ? !bank_b
                             : (fifo_out_valid ? fifo_head.addr[2] : 1'b0);

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         dram_addr_a_out    <= '0;
         dram_addr_b_out    <= '0;
         row_strobe_a_n_out <= 1'b1;
         row_strobe_b_n_out <= 1'b1;
         col_strobe_a_n_out <= 4'hf;
         col_strobe_b_n_out <= 4'hf;
         mem_write_a_n_out  <= 1'b1;
         mem_write_b_n_out  <= 1'b1;
      end else begin
         dram_addr_a_out <= (state == ST_ROW) ? row_addr : col_addr;
         dram_addr_b_out <= (state == ST_ROW) ? row_addr : col_addr;
         // R7 both banks open the same row so a burst can interleave
         row_strobe_a_n_out <= !(state == ST_ROW || active ||
                                 (state == ST_REFR && cnt != '0));
         row_strobe_b_n_out <= !(state == ST_ROW || active ||
                                 (state == ST_REFR && cnt != '0));
         // R8 column strobes per byte lane, refresh strobes all
         col_strobe_a_n_out <= (state == ST_REFR) ? 4'h0 :
                               ((active && !bank_b) ? ~cur.lanes : 4'hf);
         col_strobe_b_n_out <= (state == ST_REFR) ? 4'h0 :
                               ((active && bank_b) ? ~cur.lanes : 4'hf);
         mem_write_a_n_out  <= !(active && cur.write && !bank_b);
         mem_write_b_n_out  <= !(active && cur.write && bank_b);
      end
   end

   // bus buffer controls
   logic data_rd;
   logic instr_rd;
   logic data_any;
   assign data_rd  = active && !cur.instr && !cur.write;
   assign instr_rd = active && cur.instr;
   assign data_any = active && !cur.instr;

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         write_latch_enable_bank_out <= 2'h0;
         buffer_ctrl_out             <= 4'hf;
      end else begin
         // R1 latch enables for data writes only
         write_latch_enable_bank_out <= {data_any && cur.write && bank_b,
                                         data_any && cur.write && !bank_b};
         // R17 buffer mode mapping, R2 R3 mode 00 transmit per bank
         case (setup.mode)
            MODE_SPLIT_TX: buffer_ctrl_out <= ~{instr_rd && bank_b,
                                                instr_rd && !bank_b,
                                                data_rd && bank_b,
                                                data_rd && !bank_b};
            MODE_SPLIT_CE: buffer_ctrl_out <= ~{instr_rd && bank_b,
                  instr_rd && !bank_b,
                  data_any && (bank_b || (cur.burst && cur.write)),
                  data_any && (!bank_b || (cur.burst && cur.write))};
            MODE_COMMON: buffer_ctrl_out <= {!instr_rd, !instr_rd,
                                             next_bank, !data_rd};
            default: buffer_ctrl_out <= {!instr_rd, !instr_rd,
                                         next_bank, !data_any};
         endcase
      end
   end

   // checks
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_col_short;
      (state == ST_COL)[*2] ##1 (state != ST_COL);
   endsequence
   sequence s_col_long;
      (state == ST_COL)[*3] ##1 (state != ST_COL);
   endsequence

   a_chain_hold_low: assert property ( // R20
      !configured |=> !chain_reset_n_out)
      else $error("chain reset released before setup");
   a_chain_release: assert property ( // R11
      $rose(configured) |=> chain_reset_n_out)
      else $error("chain reset not released after setup");
   a_setup_frozen: assert property ( // R23
      configured |=> configured && $stable(setup))
      else $error("setup changed after capture");
   a_ras_short: assert property ( // R16
      (state == ST_ROW && setup.ras_short) |=> s_col_short)
      else $error("short row strobe length wrong");
   a_ras_long: assert property ( // R16
      (state == ST_ROW && !setup.ras_short) |=> s_col_long)
      else $error("long row strobe length wrong");
   a_burst_rate: assert property ( // R7
      (state == ST_BURST && fast_word) |-> word_done)
      else $error("fast burst missed a word");
   a_slow_write: assert property ( // R15
      (state == ST_BURST && !fast_word && !word_done) |=> word_done)
      else $error("two clock burst write wrong");
   a_latch_data_only: assert property ( // R1
      write_latch_enable_bank_out != 2'h0 |->
         $past(cur.write && !cur.instr))
      else $error("latch enable outside data write");
   a_single_ready: assert property ( // R6
      !(!data_ready_n_out && !instr_ready_n_out))
      else $error("both sides answered at once");
   a_precharge_len: assert property ( // R5
      $rose(state == ST_PRECH) |-> (state == ST_PRECH)[*2] ##1
         (state == ST_IDLE))
      else $error("precharge length wrong");
   a_common_instr: assert property ( // R17
      (setup.mode == MODE_COMMON) |=>
         buffer_ctrl_out[3] == buffer_ctrl_out[2])
      else $error("common instruction outputs differ");
endmodule
`default_nettype wire

/* File: include/dram_ctrl_pkg.sv */
package dram_ctrl_pkg;
   // array shape
   localparam int NUM_BANKS      = 2;
   localparam int NUM_LANES      = 4;
   localparam int DRAM_ADDR_W    = 11;
   localparam int REQ_FIFO_DEPTH = 16;
   // setup word field positions
   localparam int CFG_MODE_LSB       = 4;
   localparam int CFG_SIZE_LSB       = 6;
   localparam int CFG_REFRESH_LSB    = 8;
   localparam int CFG_BYTE_ORDER_BIT = 16;
   localparam int CFG_RAS_SHORT_BIT  = 17;
   localparam int CFG_BURST_FAST_BIT = 18;
   localparam int CFG_BASE_LSB       = 19;
   localparam logic [31:0] SETUP_WORD_RESET = 32'h0000_0000;
   // cycle counts
   localparam logic [3:0] RAS_SHORT_CYCLES   = 4'h3;
   localparam logic [3:0] RAS_LONG_CYCLES    = 4'h4;
   localparam logic [3:0] PRECHARGE_CYCLES   = 4'h2;
   localparam logic [3:0] REFRESH_RAS_CYCLES = 4'h3;
   localparam logic [3:0] REFRESH_PRESCALE   = 4'hf;
   // buffer modes and transfer sizes
   localparam logic [1:0] MODE_SPLIT_TX = 2'h0;
   localparam logic [1:0] MODE_SPLIT_CE = 2'h1;
   localparam logic [1:0] MODE_COMMON   = 2'h2;
   localparam logic [2:0] OPT_WORD      = 3'h0;
   localparam logic [2:0] OPT_BYTE      = 3'h1;
   localparam logic [2:0] OPT_HALF      = 3'h2;
   localparam logic [3:0] LANES_ALL     = 4'hf;

   typedef struct packed {
      logic [12:0] base;
      logic        burst_fast;
      logic        ras_short;
      logic        big_endian;
      logic [5:0]  refresh;
      logic [1:0]  size;
      logic [1:0]  mode;
   } setup_t;

   typedef struct packed {
      logic        instr;
      logic        write;
      logic        burst;
      logic [31:0] addr;
      logic [3:0]  lanes;
   } req_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ROW, ST_COL, ST_BURST, ST_PRECH, ST_REFR
   } state_t;

   function automatic setup_t decode_setup(input logic [31:0] w);
      setup_t s;
      s.base       = w[31:CFG_BASE_LSB];
      s.burst_fast = w[CFG_BURST_FAST_BIT];
      s.ras_short  = w[CFG_RAS_SHORT_BIT];
      s.big_endian = w[CFG_BYTE_ORDER_BIT];
      s.refresh    = w[CFG_REFRESH_LSB +: 6];
      s.size       = w[CFG_SIZE_LSB +: 2];
      s.mode       = w[CFG_MODE_LSB +: 2];
      return s;
   endfunction

   // upper address bits that select the block, per size code
   function automatic logic [31:0] block_mask(input logic [1:0] size);
      case (size)
         2'h0:    return 32'hfff8_0000;
         2'h1:    return 32'hffe0_0000;
         2'h2:    return 32'hff80_0000;
         default: return 32'hfe00_0000;
      endcase
   endfunction

   // column mask: 8 to 11 address bits per size code
   function automatic logic [10:0] col_mask(input logic [1:0] size);
      return 11'h7ff >> (2'h3 - size);
   endfunction
endpackage

/* File: core/req_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module req_fifo #(
   parameter int WIDTH = 39,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   // fill side
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   // drain side
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
         $error("req_fifo depth must be a power of two, at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign in_ready_out  = (count != (AW+1)'(DEPTH));
   assign out_valid_out = (count != '0);
   assign out_data_out  = mem[rd_ptr];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

/* File: dv/dram_array_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dram_array_model (
   // clock and bench control
   input  wire logic       clk_in,
   input  wire logic       clr_in,
   // strobes from the controller
   input  wire logic       row_a_n_in,
   input  wire logic       row_b_n_in,
   input  wire logic [3:0] col_a_n_in,
   input  wire logic [3:0] col_b_n_in,
   input  wire logic [1:0] latch_in,
   // what the array saw
   output logic      [3:0] ras_len_out,
   output logic      [3:0] lanes_a_out,
   output logic      [3:0] lanes_b_out,
   output logic      [1:0] latch_seen_out
);
   logic [3:0] run;
   // longest row strobe run, so the bench can judge the row period
   always_ff @(posedge clk_in) begin
      run <= (clr_in || (row_a_n_in && row_b_n_in)) ? 4'h0 : run + 4'h1;
      if (clr_in) begin
         ras_len_out    <= 4'h0;
         lanes_a_out    <= 4'h0;
         lanes_b_out    <= 4'h0;
         latch_seen_out <= 2'h0;
      end else begin
         if (run + 4'h1 > ras_len_out && !(row_a_n_in && row_b_n_in)) begin
            ras_len_out <= run + 4'h1;
         end
         lanes_a_out    <= lanes_a_out | ~col_a_n_in;
         lanes_b_out    <= lanes_b_out | ~col_b_n_in;
         latch_seen_out <= latch_seen_out | latch_in;
      end
   end
endmodule
`default_nettype wire

/* File: dv/test_burst_dram_controller_core.sv */
`timescale 1ns/1ps
`default_nettype none
module test_burst_dram_controller_core;
   import dram_ctrl_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, rnw = 1'b1, dreq_n = 1'b1, clr = 1'b0;
   logic [2:0]  opt = 3'h0;
   logic        bvalid = 1'b1;
   logic [31:0] addr = 32'h0;
   logic        drdy_n, chain_n, pen_n, rsa, rsb, mwa, mwb;
   logic [3:0]  csa, csb, bc, rlen, la, lb;
   logic [10:0] aa, ab;
   logic [1:0]  le, les;
   int          miscompares = 0, num_checks = 0, cyc = 0, n;
   burst_dram_controller_core u_dut (.core_clk_in(clk), .rst_in(rst),
      .addr_in(addr), .bus_invalid_n_in(bvalid), .read_not_write_in(rnw),
      .data_req_n_in(dreq_n), .data_burst_req_n_in(1'b1),
      .data_req_type_n_in(2'h0), .data_opt_n_in(opt), .instr_req_n_in(1'b1),
      .instr_burst_req_n_in(1'b1), .instr_req_type_in(1'b0),
      .data_ready_n_out(drdy_n), .data_burst_ack_n_out(),
      .instr_ready_n_out(), .instr_burst_ack_n_out(),
      .pipeline_enable_n_out(pen_n), .chain_reset_n_out(chain_n),
      .dram_addr_a_out(aa), .dram_addr_b_out(ab), .row_strobe_a_n_out(rsa),
      .row_strobe_b_n_out(rsb), .col_strobe_a_n_out(csa),
      .col_strobe_b_n_out(csb), .mem_write_a_n_out(mwa),
      .mem_write_b_n_out(mwb), .write_latch_enable_bank_out(le),
      .buffer_ctrl_out(bc));
   dram_array_model u_mem (.clk_in(clk), .clr_in(clr), .row_a_n_in(rsa),
      .row_b_n_in(rsb), .col_a_n_in(csa), .col_b_n_in(csb), .latch_in(le),
      .ras_len_out(rlen), .lanes_a_out(la), .lanes_b_out(lb),
      .latch_seen_out(les));
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one pulsed data request; n is the cycle ready came back, 0 for none
   // ready launched by the taking edge is seen as n == 1
   task automatic acc(input logic [31:0] a, input logic rd,
                      input logic [2:0] o, input logic v = 1'b1);
      @(posedge clk);
      clr <= 1'b1;
      addr <= a;
      rnw <= rd;
      opt <= o;
      bvalid <= v;
      dreq_n <= 1'b0;
      @(posedge clk);
      clr <= 1'b0;
      bvalid <= 1'b1;
      dreq_n <= 1'b1;
      n = 0;
      for (int i = 1; i < 14; i++) begin
         #1;
         if (drdy_n === 1'b0 && n == 0) n = i;
         @(posedge clk);
      end
      #1;
   endtask
   task automatic wrap_up;
      if (miscompares == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         miscompares++;
         wrap_up();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      // chained reset low in reset
      chk(chain_n, 1'b0);
      chk(bc, 4'hf);
      acc(32'h0000_0000, 1'b0, OPT_WORD);
      chk(n, 0);
      chk(chain_n, 1'b0);
      chk(pen_n, 1'b1);
      // setup: 3 clock row strobe, mode 00, smallest block at 0
      acc(32'h0002_3f00, 1'b1, OPT_WORD);
      chk(n, 1);
      chk(chain_n, 1'b1);
      chk(pen_n, 1'b0);
      // bus marked invalid: request must be ignored
      acc(32'h0000_0004, 1'b1, OPT_WORD, 1'b0);
      chk(n, 0);
      acc(32'h0000_0004, 1'b1, OPT_WORD);
      chk(n != 0, 1'b1);
      chk(rlen, 32'(RAS_SHORT_CYCLES));
      chk(lb, LANES_ALL);
      chk(les, 2'h0);
      acc(32'h0008_0000, 1'b1, OPT_WORD);
      chk(n, 0);
      // byte write kept inside one word
      acc(32'h0000_0001, 1'b0, OPT_BYTE);
      chk(la, 4'h2);
      chk(les, 2'h1);
      acc(32'h0002_3f00, 1'b1, OPT_WORD);
      chk(n > 1, 1'b1);
      chk(chain_n, 1'b1);
      wrap_up();
   end
endmodule
`default_nettype wire
